/* File: design/gpio_level_pkg.sv */
// Package with register map, field layout and timing constants of the pin level controller.
// Behaviour
// [RL1] Pin index 0 to 4 selects a bidirectional pin and 5 to 12 an indicator pin; only 0 to 12 are legal.
// [RL2] Output state 0 drives low, 100 drives high and 1 to 99 gives a 100 Hz PWM of that duty.
// [RL3] Every pin's input level is sampled at 50 Hz regardless of host reads.
// [RL4] Each pin remembers rising and falling edges seen in the samples since the last query.
// [RL5] The reported level is debounced so short bounces give no level change or edge.
// [RL6] A write of 2 bytes updates the output state only; 3 bytes also updates the configuration.
// [RL7] The low three configuration bits choose how the high and low levels are driven.
// [RL8] Drive mode 110 is reserved and answered with an error; legal bytes are 0 to 15 except 6 and 14.
// [RL9] The function bit set gives the pin to the host; clear gives it back to its default function.
// [RL10] The configuration byte applies only to pins 0 to 4; indicator pins ignore it.
// [RL11] A read answer carries the index, output state, PWM output value and configuration byte.
// [RL12] With a resistive pull-up an open input reads 1 and a grounded input reads 0.
// [RL13] Pins 1, 2 and 3 serve power sense, power control and restart while their function bit is 0.
// [RL14] Requests use type 0x22, answers type 0x62, and a write answer has no data bytes.
// [RL15] By default the indicator pins drive the front lights with PWM.
// [RL16] Answering a query for a pin clears that pin's edge flags.
package gpio_level_pkg;
    localparam int          NUM_PINS      = 13;
    localparam int          NUM_GPIO      = 5;
    localparam logic [7:0]  CMD_TYPE      = 8'h22;
    localparam logic [7:0]  RSP_TYPE      = 8'h62;
    localparam logic [7:0]  LEVEL_HIGH    = 8'h64;
    localparam logic [7:0]  ERR_BAD_INDEX = 8'h01;
    localparam logic [7:0]  ERR_BAD_CFG   = 8'h02;
    localparam logic [7:0]  ERR_BAD_LEN   = 8'h03;
    localparam logic [7:0]  ERR_BAD_TYPE  = 8'h04;
    localparam logic [7:0]  RST_STATE     = 8'h00;
    localparam logic [7:0]  RST_CFG       = 8'h02;
    // Wishbone byte offsets.
    localparam logic [7:0]  REG_CMD       = 8'h00;
    localparam logic [7:0]  REG_RSP0      = 8'h04;
    localparam logic [7:0]  REG_RSP1      = 8'h08;
    localparam logic [7:0]  REG_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
    localparam logic [7:0]  REG_LEVELS    = 8'h14;
    localparam logic [7:0]  REG_DEFAULT   = 8'h18;
    // Status bit positions.
    localparam int          IRQ_DONE      = 0;
    localparam int          IRQ_ERROR     = 1;
    localparam int          IRQ_EDGE      = 2;
    localparam int          IRQ_BITS      = 3;
    // Configuration field layout.
    localparam int          CFG_FUNC_BIT  = 3;
    localparam logic [2:0]  MODE_RESERVED = 3'b110;
    // Timing.
    localparam int          CLK_HZ        = 50_000_000;
    localparam int          PWM_HZ        = 100;
    localparam int          SAMPLE_HZ     = 50;
    localparam int          PWM_STEP_CYC  = CLK_HZ / (PWM_HZ * 100);
    localparam int          SAMPLE_CYC    = CLK_HZ / SAMPLE_HZ;

    typedef enum logic [2:0] {
        MODE_STRONG_HI_RES_LO,
        MODE_STRONG_BOTH,
        MODE_HIZ,
        MODE_RES_HI_STRONG_LO,
        MODE_STRONG_HI_HIZ_LO,
        MODE_STRONG_BOTH_B,
        MODE_RSVD,
        MODE_HIZ_HI_STRONG_LO
    } drive_mode_e;

    typedef struct packed {
        logic [7:0] kind;
        logic [7:0] length;
        logic [7:0] data0;
        logic [7:0] data1;
        logic [7:0] data2;
    } cmd_s;

    typedef struct packed {
        logic [NUM_GPIO-1:0] out;
        logic [NUM_GPIO-1:0] oe;
        logic [NUM_GPIO-1:0] pull_up;
        logic [NUM_GPIO-1:0] pull_down;
    } gpio_drive_s;
endpackage

/* File: design/gpio_pin_level_control.sv */
// Pin level controller: five bidirectional pins and eight indicator pins behind Wishbone.
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module gpio_pin_level_control
(
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic [7:0]                             adr_i,
    input  wire logic [31:0]                            dat_i,
    output logic      [31:0]                            dat_o,
    input  wire logic                                   we_i,
    input  wire logic [3:0]                             sel_i,
    input  wire logic                                   cyc_i,
    input  wire logic                                   stb_i,
    output logic                                        ack_o,
    output logic                                        err_o,
    output logic                                        irq_o,
    input  wire logic [gpio_level_pkg::NUM_GPIO-1:0]    pin_i,
    output gpio_level_pkg::gpio_drive_s                 pin_drive_o,
    output logic [gpio_level_pkg::NUM_PINS-1:gpio_level_pkg::NUM_GPIO] indicator_o,
    input  wire logic [gpio_level_pkg::NUM_GPIO-1:0]    default_out_i,
    input  wire logic [gpio_level_pkg::NUM_GPIO-1:0]    default_oe_i,
    output logic                                        host_power_sense_o
);
    import gpio_level_pkg::*;

    logic [7:0]          out_state [NUM_PINS];
    logic [3:0]          cfg       [NUM_PINS];
    logic [NUM_PINS-1:0] pwm_level;
    logic [7:0]          pwm_phase;
    logic [31:0]         pwm_div;
    logic [31:0]         sample_div;
    logic                sample_tick;
    logic [NUM_GPIO-1:0] sync1;
    logic [NUM_GPIO-1:0] sync2;
    logic [NUM_GPIO-1:0] sync3;
    logic [NUM_GPIO-1:0] pin_stable;
    logic [NUM_GPIO-1:0] last_sample;
    logic [NUM_GPIO-1:0] debounced;
    logic [NUM_GPIO-1:0] rise_seen;
    logic [NUM_GPIO-1:0] fall_seen;
    logic [NUM_GPIO-1:0] next_debounced;
    logic [NUM_GPIO-1:0] new_rise;
    logic [NUM_GPIO-1:0] new_fall;
    logic [31:0]         rsp0;
    logic [31:0]         rsp1;
    logic [IRQ_BITS-1:0] irq_stat;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_set;
    logic                req;
    logic                wr_cmd;
    logic                rd_stat;
    logic                wr_stat;
    logic                wr_mask;
    logic                known;
    cmd_s                cmd;
    logic [3:0]          q_idx;
    logic                cmd_err;
    logic [7:0]          cmd_code;
    logic [3:0]          cfg_stage;

    function automatic logic pwm_out(input logic [7:0] state, input logic [7:0] phase);
        if (state >= LEVEL_HIGH)
            pwm_out = 1'b1;
        else
            pwm_out = phase < state;
    endfunction

    assign req     = cyc_i && stb_i && !ack_o && !err_o;
    assign known   = adr_i == REG_CMD || adr_i == REG_RSP0 || adr_i == REG_RSP1
                     || adr_i == REG_IRQ_STAT || adr_i == REG_IRQ_MASK
                     || adr_i == REG_LEVELS || adr_i == REG_DEFAULT;
    assign wr_cmd  = req && we_i && adr_i == REG_CMD && sel_i == 4'hF;
    assign wr_stat = req && we_i && adr_i == REG_IRQ_STAT && sel_i[0];
    assign wr_mask = req && we_i && adr_i == REG_IRQ_MASK && sel_i[0];
    assign rd_stat = req && !we_i;
    // Command word: [31:24] type, [23:16] data length, [15:8] index, [7:0] state; byte
    // [2] of a three-byte write comes from the default register's low four bits.
    assign cmd.kind   = dat_i[31:24];
    assign cmd.length = dat_i[23:16];
    assign cmd.data0  = dat_i[15:8];
    assign cmd.data1  = dat_i[7:0];
    assign cmd.data2  = {4'h0, cfg_stage};
    assign q_idx      = cmd.data0[3:0];

    always_comb
    begin
        cmd_err  = 1'b1;
        cmd_code = 8'h00;
        if (cmd.kind != CMD_TYPE)
            cmd_code = ERR_BAD_TYPE; // [RL14]
        else if (cmd.data0 >= 8'(NUM_PINS))
            cmd_code = ERR_BAD_INDEX; // [RL1]
        else if (cmd.length == 8'h01)
            cmd_err = 1'b0;
        else if (cmd.length != 8'h02 && cmd.length != 8'h03)
            cmd_code = ERR_BAD_LEN; // [RL6]
        else if (cmd.data1 > LEVEL_HIGH)
            cmd_code = ERR_BAD_CFG;
        else if (cmd.length == 8'h03 && cmd.data0 < 8'(NUM_GPIO)
                 && cfg_stage[2:0] == MODE_RESERVED)
            cmd_code = ERR_BAD_CFG; // [RL8]
        else
            cmd_err = 1'b0;
    end

    // Bus handshake: one wait-free cycle, error for unmapped addresses.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end
        else
        begin
            ack_o <= req && known;
            err_o <= req && !known;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (rd_stat)
        begin
            if (adr_i == REG_RSP0)
                dat_o <= rsp0;
            else if (adr_i == REG_RSP1)
                dat_o <= rsp1;
            else if (adr_i == REG_IRQ_STAT)
                dat_o <= {29'h0, irq_stat};
            else if (adr_i == REG_IRQ_MASK)
                dat_o <= {29'h0, irq_mask};
            else if (adr_i == REG_LEVELS)
                dat_o <= {17'h0, fall_seen, rise_seen, debounced};
            else if (adr_i == REG_DEFAULT)
                dat_o <= {28'h0, cfg_stage};
            else
                dat_o <= 32'h0000_0000;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_stage <= RST_CFG[3:0];
        else if (req && we_i && adr_i == REG_DEFAULT && sel_i[0])
            cfg_stage <= dat_i[3:0];
    end
    // Pin state and configuration storage.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_PINS; i++)
            begin
                out_state[i] <= RST_STATE;
                cfg[i]       <= RST_CFG[3:0];
            end
        end
        else if (wr_cmd && !cmd_err && cmd.length != 8'h01)
        begin
            out_state[q_idx] <= cmd.data1; // [RL6]
            if (cmd.length == 8'h03 && cmd.data0 < 8'(NUM_GPIO))
                cfg[q_idx] <= cmd.data2[3:0]; // [RL10]
        end
    end

    // Response registers: rsp0 holds type, length and status, rsp1 the read data.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rsp0 <= 32'h0000_0000;
            rsp1 <= 32'h0000_0000;
        end
        else if (wr_cmd)
        begin
            rsp0 <= {RSP_TYPE, 8'h00, cmd_code, 8'h00}; // [RL14]
            rsp1 <= 32'h0000_0000;
            if (!cmd_err && cmd.length == 8'h01)
            begin
                rsp0[23:16] <= 8'h04;
                rsp1 <= {cmd.data0, out_state[q_idx], 7'h00, pwm_level[q_idx],
                         4'h0, cfg[q_idx]}; // [RL11]
            end
        end
    end

    // PWM time base: 100 steps of 100 us give a 100 Hz period.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pwm_div   <= 32'h0000_0000;
            pwm_phase <= 8'h00;
        end
        else if (pwm_div == 32'(PWM_STEP_CYC - 1))
        begin
            pwm_div   <= 32'h0000_0000;
            pwm_phase <= (pwm_phase == LEVEL_HIGH - 8'h01) ? 8'h00 : pwm_phase + 8'h01;
        end
        else
            pwm_div <= pwm_div + 32'h0000_0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pwm_level <= '0;
        else
            for (int i = 0; i < NUM_PINS; i++)
                pwm_level[i] <= pwm_out(out_state[i], pwm_phase); // [RL2]
    end
    // Indicator pins are PWM outputs and never see the configuration byte.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            indicator_o <= '0;
        else
            indicator_o <= pwm_level[NUM_PINS-1:NUM_GPIO]; // [RL15] [RL10]
    end

    // Drive mode decode for the bidirectional pins.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pin_drive_o <= '0;
        else
            for (int i = 0; i < NUM_GPIO; i++)
            begin
                pin_drive_o.out[i]       <= pwm_level[i];
                pin_drive_o.oe[i]        <= 1'b0;
                pin_drive_o.pull_up[i]   <= 1'b0;
                pin_drive_o.pull_down[i] <= 1'b0;
                if (!cfg[i][CFG_FUNC_BIT])
                begin
                    pin_drive_o.out[i] <= default_out_i[i]; // [RL9] [RL13]
                    pin_drive_o.oe[i]  <= default_oe_i[i];
                end
                else
                    case (drive_mode_e'(cfg[i][2:0])) // [RL7]
                        MODE_STRONG_HI_RES_LO:
                        begin
                            pin_drive_o.oe[i]        <= pwm_level[i];
                            pin_drive_o.pull_down[i] <= !pwm_level[i];
                        end
                        MODE_STRONG_BOTH, MODE_STRONG_BOTH_B:
                            pin_drive_o.oe[i] <= 1'b1;
                        MODE_RES_HI_STRONG_LO:
                        begin
                            pin_drive_o.oe[i]      <= !pwm_level[i];
                            pin_drive_o.pull_up[i] <= pwm_level[i]; // [RL12]
                        end
                        MODE_STRONG_HI_HIZ_LO:
                            pin_drive_o.oe[i] <= pwm_level[i];
                        MODE_HIZ_HI_STRONG_LO:
                            pin_drive_o.oe[i] <= !pwm_level[i];
                        default:
                            pin_drive_o.oe[i] <= 1'b0;
                    endcase
            end
    end

    // Input synchroniser; a change counts when the second and third stages agree.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1      <= '0;
            sync2      <= '0;
            sync3      <= '0;
            pin_stable <= '0;
        end
        else
        begin
            sync1 <= pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < NUM_GPIO; i++)
                if (sync2[i] == sync3[i])
                    pin_stable[i] <= sync3[i];
        end
    end
    assign sample_tick = sample_div == 32'(SAMPLE_CYC - 1);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sample_div <= 32'h0000_0000;
        else if (sample_tick)
            sample_div <= 32'h0000_0000;
        else
            sample_div <= sample_div + 32'h0000_0001; // [RL3]
    end

    // A level is accepted only when two consecutive 50 Hz samples agree.
    always_comb
    begin
        next_debounced = debounced;
        for (int i = 0; i < NUM_GPIO; i++)
            if (pin_stable[i] == last_sample[i])
                next_debounced[i] = pin_stable[i]; // [RL5]
        new_rise = sample_tick ? (next_debounced & ~debounced) : '0;
        new_fall = sample_tick ? (~next_debounced & debounced) : '0;
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            last_sample <= '0;
            debounced   <= '0;
        end
        else if (sample_tick)
        begin
            last_sample <= pin_stable; // [RL3]
            debounced   <= next_debounced;
        end
    end

    // Edge flags: a new edge wins over the clear made by a query.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rise_seen <= '0;
            fall_seen <= '0;
        end
        else
            for (int i = 0; i < NUM_GPIO; i++)
            begin
                if (new_rise[i])
                    rise_seen[i] <= 1'b1; // [RL4]
                else if (wr_cmd && !cmd_err && cmd.length == 8'h01 && q_idx == 4'(i))
                    rise_seen[i] <= 1'b0; // [RL16]
                if (new_fall[i])
                    fall_seen[i] <= 1'b1; // [RL4]
                else if (wr_cmd && !cmd_err && cmd.length == 8'h01 && q_idx == 4'(i))
                    fall_seen[i] <= 1'b0; // [RL16]
            end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            host_power_sense_o <= 1'b0;
        else
            host_power_sense_o <= !cfg[1][CFG_FUNC_BIT] && debounced[1]; // [RL13]
    end
    assign irq_set = {|(new_rise | new_fall), wr_cmd && cmd_err, wr_cmd};
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
        end
        else
        begin
            irq_stat <= irq_set | (irq_stat & ~(wr_stat ? dat_i[IRQ_BITS-1:0] : '0));
            if (wr_mask)
                irq_mask <= dat_i[IRQ_BITS-1:0];
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_stat & irq_mask);
    end
endmodule

/* File: sim/gpio_pin_level_control_chk.sv */
// Checker of bus, interrupt and pin drive behaviour at the controller's ports.
`timescale 1ns/1ps
module gpio_pin_level_control_chk
(
    input wire logic                            clk_i,
    input wire logic                            rst_i,
    input wire logic [7:0]                      adr_i,
    input wire logic [31:0]                     dat_i,
    input wire logic [31:0]                     dat_o,
    input wire logic                            we_i,
    input wire logic                            cyc_i,
    input wire logic                            stb_i,
    input wire logic                            ack_o,
    input wire logic                            err_o,
    input wire logic                            irq_o,
    input wire gpio_level_pkg::gpio_drive_s     pin_drive_o,
    input wire logic [12:5]                     indicator_o
);
    import gpio_level_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire req = cyc_i && stb_i;
    wire mapped = (adr_i <= REG_DEFAULT) && (adr_i[1:0] == 2'b00);

    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    answer_time_a: assert property ($rose(req) |=> (ack_o ^ err_o))
        else $error("request not answered in one cycle");
    ack_cause_a: assert property ((ack_o || err_o) |-> $past(req))
        else $error("answer without request");
    err_unmapped_a: assert property ($rose(req) && !mapped |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    ack_mapped_a: assert property ($rose(req) && mapped |=> ack_o && !err_o)
        else $error("mapped access not acknowledged");
    read_hold_a: assert property (!$stable(dat_o) |-> ack_o && !we_i)
        else $error("read data changed outside a read");
    pull_excl_a: assert property ((pin_drive_o.pull_up & pin_drive_o.pull_down) == 5'h00)
        else $error("pull-up and pull-down both on");
    mask_off_a: assert property ($rose(req) && we_i && adr_i == REG_IRQ_MASK
        && dat_i[2:0] == 3'h0 |-> ##3 !irq_o[*3])
        else $error("interrupt with all sources masked");
    reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !ack_o && !err_o
        && !irq_o && indicator_o == 8'h00 && pin_drive_o.oe == 5'h00)
        else $error("outputs active after reset");

    read_c: cover property ($rose(req) && !we_i && mapped);
    refuse_c: cover property (err_o);
    irq_c: cover property ($rose(irq_o));
endmodule

/* File: sim/gpio_pin_level_control_tb.sv */
// Self-checking bench of the pin level controller driven over Wishbone.
`timescale 1ns/1ps
module gpio_pin_level_control_tb;
    import gpio_level_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        we_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [4:0]  default_out_i = 5'h00;
    logic [4:0]  default_oe_i = 5'h00;
    logic [4:0]  ext_en = 5'h00;
    logic [4:0]  pin_i;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic        ack_o;
    logic        err_o;
    logic        irq_o;
    logic        berr;
    logic        host_power_sense_o;
    logic [12:5] indicator_o;
    gpio_drive_s pin_drive_o;
    int          errors = 0;
    int          check_count = 0;

    gpio_pin_level_control DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .err_o(err_o), .irq_o(irq_o), .pin_i(pin_i), .pin_drive_o(pin_drive_o),
        .indicator_o(indicator_o), .default_out_i(default_out_i),
        .default_oe_i(default_oe_i), .host_power_sense_o(host_power_sense_o));
    pin_world u_world (.clk_i(clk_i), .drive_i(pin_drive_o), .ext_en_i(ext_en),
        .ext_val_i(5'h00), .level_o(pin_i));

    always #10 clk_i = ~clk_i;

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        adr_i <= a;
        we_i <= w;
        dat_i <= d;
        sel_i <= 4'hF;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        rd = dat_o;
        berr = err_o;
        if (n == 20)
            check(32'h1, 32'h0);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    // Sends a command, then checks the answer header.
    task automatic cmd(input logic [31:0] w, input logic [7:0] e_err, input logic [7:0] e_len);
        bus(REG_CMD, 1'b1, w);
        bus(REG_RSP0, 1'b0, 32'h0);
        check(rd[31:8], {RSP_TYPE, e_len, e_err});
    endtask

    // The upper bits of the configuration byte are always sent as zero.
    task automatic setpin(input logic [7:0] idx, input logic [7:0] st, input logic [3:0] cfg,
        input logic [7:0] e_err);
        bus(REG_DEFAULT, 1'b1, {28'h0, cfg});
        cmd({CMD_TYPE, 8'd3, idx, st}, e_err, 8'd0);
        repeat (2) @(posedge clk_i);
    endtask

    task automatic query(input logic [7:0] idx, input logic [31:0] exp);
        cmd({CMD_TYPE, 8'd1, idx, 8'd0}, 8'd0, 8'd4);
        bus(REG_RSP1, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    function automatic logic [3:0] drv(input int m, input logic l);
        case (m)
            0: return l ? 4'b1001 : 4'b0010;
            1, 5: return {3'b100, l};
            3: return l ? 4'b0100 : 4'b1000;
            4: return l ? 4'b1001 : 4'b0000;
            7: return l ? 4'b0000 : 4'b1000;
            default: return 4'b0000;
        endcase
    endfunction

    task automatic t_modes();
        logic [3:0] e;
        for (int m = 0; m < 8; m++)
        begin
            for (int l = 0; l < 2; l++)
            begin
                if (m != 6)
                begin
                    setpin(8'd4, l ? LEVEL_HIGH : 8'd0, {1'b1, m[2:0]}, 8'd0);
                    e = drv(m, l[0]);
                    check({pin_drive_o.oe[4], pin_drive_o.pull_up[4], pin_drive_o.pull_down[4],
                        pin_drive_o.out[4] & pin_drive_o.oe[4]}, e);
                    if (e[3:1] != 3'b000)
                        check(pin_i[4], e[3] ? e[0] : e[2]);
                end
            end
        end
        setpin(8'd4, LEVEL_HIGH, 4'h9, 8'd0);
        setpin(8'd4, 8'd0, 4'hE, ERR_BAD_CFG);
        check({pin_drive_o.oe[4], pin_drive_o.pull_up[4], pin_drive_o.pull_down[4],
            pin_drive_o.out[4]}, 4'b1001);
    endtask

    task automatic t_errors();
        logic [31:0] w[4] = '{{CMD_TYPE, 8'd1, 8'd13, 8'd0}, {CMD_TYPE, 8'd2, 8'd0, 8'd101},
            {CMD_TYPE, 8'd4, 8'd0, 8'd0}, {8'h23, 8'd2, 8'd0, 8'd0}};
        logic [7:0] c[4] = '{ERR_BAD_INDEX, ERR_BAD_CFG, ERR_BAD_LEN, ERR_BAD_TYPE};
        for (int i = 0; i < 4; i++)
            cmd(w[i], c[i], 8'd0);
        query(8'd0, 32'h0000_0002);
        setpin(8'd0, LEVEL_HIGH, 4'h9, 8'd0);
        bus(REG_DEFAULT, 1'b1, 32'h0000_000B);
        cmd({CMD_TYPE, 8'd2, 8'd0, 8'd0}, 8'd0, 8'd0);
        query(8'd0, 32'h0000_0009);
    endtask

    task automatic t_pins();
        default_oe_i <= 5'h04;
        default_out_i <= 5'h04;
        repeat (3) @(posedge clk_i);
        check({pin_drive_o.oe[2], pin_drive_o.out[2]}, 2'b11);
        default_out_i <= 5'h00;
        repeat (3) @(posedge clk_i);
        check({pin_drive_o.oe[2], pin_drive_o.out[2]}, 2'b10);
        setpin(8'd2, LEVEL_HIGH, 4'hA, 8'd0);
        check(pin_drive_o.oe[2], 1'b0);
        setpin(8'd5, LEVEL_HIGH, 4'h9, 8'd0);
        check(indicator_o[5], 1'b1);
        query(8'd5, {8'd5, LEVEL_HIGH, 8'h01, RST_CFG});
        bus(REG_LEVELS, 1'b0, 32'h0);
        check(rd, 32'h0);
        check(host_power_sense_o, 1'b0);
        bus(8'h1C, 1'b0, 32'h0);
        check(berr, 1'b1);
    endtask

    task automatic t_irq();
        bus(REG_IRQ_MASK, 1'b1, 32'h0);
        bus(REG_IRQ_STAT, 1'b1, 32'h7);
        cmd({CMD_TYPE, 8'd2, 8'd6, 8'd0}, 8'd0, 8'd0);
        bus(REG_IRQ_STAT, 1'b0, 32'h0);
        check(rd[1:0], 2'b01);
        check(irq_o, 1'b0);
        bus(REG_IRQ_MASK, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b1);
        bus(REG_IRQ_STAT, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        check(irq_o, 1'b0);
    endtask

    // Runs while the phase is still 0: both pins start high and fall when the phase
    // reaches their state, so the falls lie two phase steps apart.
    task automatic t_pwm();
        int n0;
        int n5;
        n0 = 0;
        n5 = 0;
        setpin(8'd0, 8'd2, 4'h9, 8'd0);
        cmd({CMD_TYPE, 8'd2, 8'd5, 8'd4}, 8'd0, 8'd0);
        check(pin_drive_o.out[0], 1'b1);
        check(indicator_o[5], 1'b1);
        while (pin_drive_o.out[0] === 1'b1 && n0 < 30000)
        begin
            @(posedge clk_i);
            n0++;
        end
        while (indicator_o[5] === 1'b1 && n5 < 30000)
        begin
            @(posedge clk_i);
            n5++;
        end
        check(n5, 2 * PWM_STEP_CYC);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_i);
        errors++;
        close_out();
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        query(8'd0, 32'h0000_0002);
        t_modes();
        t_errors();
        t_pins();
        t_irq();
        t_pwm();
        close_out();
    end
endmodule

bind gpio_pin_level_control gpio_pin_level_control_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .err_o(err_o), .irq_o(irq_o), .pin_drive_o(pin_drive_o),
    .indicator_o(indicator_o));

/* File: sim/pin_world.sv */
// Outside world of the five bidirectional pins: wire resolution with pulls and switches.
`timescale 1ns/1ps
module pin_world
(
    input  wire logic                                clk_i,
    input  wire gpio_level_pkg::gpio_drive_s         drive_i,
    input  wire logic [gpio_level_pkg::NUM_GPIO-1:0] ext_en_i,
    input  wire logic [gpio_level_pkg::NUM_GPIO-1:0] ext_val_i,
    output logic      [gpio_level_pkg::NUM_GPIO-1:0] level_o
);
    import gpio_level_pkg::*;
    // A floating pin shows a toggling value so that no stale level can pass for a drive.
    logic [NUM_GPIO-1:0] float_q = 5'h00;
    always_ff @(posedge clk_i)
    begin
        float_q <= ~float_q;
    end
    always_comb
    begin
        for (int i = 0; i < NUM_GPIO; i++)
        begin
            if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (drive_i.oe[i])
                level_o[i] = drive_i.out[i];
            else if (drive_i.pull_up[i])
                level_o[i] = 1'b1;
            else if (drive_i.pull_down[i])
                level_o[i] = 1'b0;
            else
                level_o[i] = float_q[i];
        end
    end
endmodule
